// File: rtl/pbr_pkg.sv
// Package: register map, field positions and reset values of the basic control/status bank
`default_nettype none
package pbr_pkg;
  // ************************************************************
  // Register space
  // ************************************************************
  localparam int unsigned   PBR_ADDR_W        = 5;
  localparam int unsigned   PBR_DATA_W        = 16;
  localparam logic [4:0]    PBR_STD_LAST      = 5'h0f;  // Last standard index
  localparam logic [4:0]    PBR_VENDOR_FIRST  = 5'h10;  // First vendor index
  localparam logic [4:0]    PBR_IDX_CONTROL   = 5'h00;
  localparam logic [4:0]    PBR_IDX_STATUS    = 5'h01;
  localparam logic [4:0]    PBR_IDX_FUNC_CTRL = 5'h1c;
  // ************************************************************
  // Control register fields
  // ************************************************************
  localparam int unsigned   PBR_CTL_RESET     = 15;
  localparam int unsigned   PBR_CTL_LOOPBACK  = 14;
  localparam int unsigned   PBR_CTL_SPEED     = 13;
  localparam int unsigned   PBR_CTL_NEG_EN    = 12;
  localparam int unsigned   PBR_CTL_PWR_DOWN  = 11;
  localparam int unsigned   PBR_CTL_ISOLATE   = 10;
  localparam int unsigned   PBR_CTL_NEG_RST   = 9;
  localparam int unsigned   PBR_CTL_DUPLEX    = 8;
  localparam int unsigned   PBR_CTL_COL_TEST  = 7;
  localparam int unsigned   PBR_FC_LOOPBACK   = 0;      // Loopback bit in function control
  localparam logic          PBR_RST_SPEED     = 1'b1;
  localparam logic          PBR_RST_DUPLEX    = 1'b1;
  localparam logic          PBR_RST_PWR_DOWN  = 1'b0;
  localparam logic          PBR_RST_ISOLATE   = 1'b0;
  localparam logic          PBR_RST_LOOPBACK  = 1'b0;
  localparam logic          PBR_RST_COL_TEST  = 1'b0;
  localparam logic [15:0]   PBR_RST_FUNC_CTRL = 16'h0000;
  // ************************************************************
  // Status register constant image
  // ************************************************************
  localparam logic [15:0]   PBR_STATUS_VALUE  = 16'h7000; // T4=0, 100F/100H/10F=1
  // ************************************************************
  // Timing
  // ************************************************************
  localparam int unsigned   PBR_SWRST_CYCLES  = 4;    // Cycles a soft reset pulse is held
  localparam logic [2:0]    PBR_SWRST_CNT     = 3'(PBR_SWRST_CYCLES);
endpackage : pbr_pkg
`default_nettype wire

// File: rtl/pbr_mode_resolve.sv
// Module: resolves effective speed, duplex and loopback from control and negotiation
`default_nettype none
module pbr_mode_resolve
  import pbr_pkg::*;
(
  input  wire logic i_neg_enable,    // Negotiation enabled
  input  wire logic i_neg_speed,     // Negotiated speed, 1=100
  input  wire logic i_neg_duplex,    // Negotiated duplex, 1=full
  input  wire logic i_ctl_speed,     // Forced speed bit
  input  wire logic i_ctl_duplex,    // Forced duplex bit
  input  wire logic i_ctl_loopback,  // Control loopback bit
  input  wire logic i_fc_loopback,   // Function control loopback bit
  output logic      o_speed_100,     // Effective speed
  output logic      o_full_duplex,   // Effective duplex
  output logic      o_loopback       // Effective loopback
);
  // Negotiation result overrides forced settings
  assign o_speed_100   = i_neg_enable ? i_neg_speed : i_ctl_speed;   // [RULE5] [RULE6]
  assign o_full_duplex = i_neg_enable ? i_neg_duplex : i_ctl_duplex; // [RULE6]
  // Loopback needs both enables
  assign o_loopback    = i_ctl_loopback & i_fc_loopback;             // [RULE3] [RULE4]
endmodule : pbr_mode_resolve
`default_nettype wire

// File: rtl/pbr_regs.sv
// Module: basic control and status registers of a 10/100 transceiver management space
// Function
// [RULE1] 32 directly addressed registers; 0h-Fh standard, 10h-1Fh vendor.
// [RULE2] Writing one to control bit 15 resets; bit self-clears, reads zero.
// [RULE3] Loopback bit returns transmit data to receive and cuts line side.
// [RULE4] Loopback also needs the vendor function control bit at 1Ch.
// [RULE5] Bit 13 selects 100/10 Mbps, resets to one, ignored under negotiation.
// [RULE6] Bit 12 enables negotiation from strap; result overrides speed and duplex.
// [RULE7] Bit 11 enters power-down; resets to zero.
// [RULE8] Leaving power-down by reset takes two writes; second re-samples straps.
// [RULE9] Bit 10 isolates from the reduced MII; resets to zero.
// [RULE10] Writing one to bit 9 restarts negotiation; bit self-clears.
// [RULE11] Bit 7 enables collision test; bits 6-0 read zero.
// [RULE12] Status bit 15 reads zero, bits 14-12 read one, all read-only.
// [RULE13] Writes to read-only bits are ignored; soft reset restores reset values.
`default_nettype none
module pbr_regs
  import pbr_pkg::*;
(
  input  wire logic        i_core_clk,        // Core clock, 100 MHz
  input  wire logic        i_rst_n,           // Async reset, active low
  input  wire logic        i_negotiation_enable_strap, // Negotiation strap pin level
  input  wire logic [4:0]  i_reg_addr,        // Register index
  input  wire logic        i_reg_wr,          // Write strobe
  input  wire logic        i_reg_rd,          // Read strobe
  input  wire logic [15:0] i_reg_wdata,       // Write data
  input  wire logic        i_neg_speed,       // Negotiated speed, 1=100
  input  wire logic        i_neg_duplex,      // Negotiated duplex, 1=full
  output logic [15:0]      o_reg_rdata,       // Read data
  output logic             o_reg_rvalid,      // Read data valid pulse
  output logic             o_soft_reset,      // Chip soft reset pulse
  output logic             o_neg_restart,     // Negotiation restart pulse
  output logic             o_power_down,      // Power-down mode
  output logic             o_isolate,         // Reduced MII isolated
  output logic             o_loopback,        // Effective loopback
  output logic             o_speed_100,       // Effective speed
  output logic             o_full_duplex,     // Effective duplex
  output logic             o_col_test         // Collision test enabled
);
  // ************************************************************
  // Control state
  // ************************************************************
  logic        ctl_loopback;
  logic        ctl_speed;
  logic        ctl_neg_en;
  logic        ctl_pwr_down;
  logic        ctl_isolate;
  logic        ctl_duplex;
  logic        ctl_col_test;
  logic [15:0] func_ctrl;
  logic [2:0]  swrst_cnt;
  logic        strap_load;
  logic        wr_ctl;
  logic        wr_fc;
  logic        full_reset;
  logic        next_speed;
  logic        next_duplex;
  logic        next_loop;

  function automatic logic [15:0] control_image(
    input logic lb, input logic sp, input logic ne, input logic pd,
    input logic iso, input logic dx, input logic ct);
    control_image = {1'b0, lb, sp, ne, pd, iso, 1'b0, dx, ct, 7'h00}; // [RULE2] [RULE10] [RULE11]
  endfunction : control_image

  // Write decode within the 32-entry space
  assign wr_ctl     = i_reg_wr && (i_reg_addr == PBR_IDX_CONTROL);   // [RULE1]
  assign wr_fc      = i_reg_wr && (i_reg_addr == PBR_IDX_FUNC_CTRL); // [RULE1]
  // Full reset only when not leaving power-down
  assign full_reset = wr_ctl && i_reg_wdata[PBR_CTL_RESET] && !ctl_pwr_down; // [RULE2] [RULE8]

  // ************************************************************
  // Strap capture after reset release and on full soft reset
  // ************************************************************
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      strap_load <= 1'b1;
    end else begin
      strap_load <= full_reset; // [RULE8]
    end
  end

  // Negotiation enable, loaded from the strap
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ctl_neg_en <= 1'b0;
    end else if (strap_load) begin
      ctl_neg_en <= i_negotiation_enable_strap; // [RULE6] [RULE8]
    end else if (wr_ctl && !i_reg_wdata[PBR_CTL_RESET]) begin
      ctl_neg_en <= i_reg_wdata[PBR_CTL_NEG_EN];
    end
  end

  // Power-down: any reset write clears it; plain write loads it from bit 11
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ctl_pwr_down <= PBR_RST_PWR_DOWN;
    end else if (wr_ctl && i_reg_wdata[PBR_CTL_RESET]) begin
      ctl_pwr_down <= PBR_RST_PWR_DOWN; // [RULE8]
    end else if (wr_ctl) begin
      ctl_pwr_down <= i_reg_wdata[PBR_CTL_PWR_DOWN]; // [RULE7]
    end
  end

  // Remaining read/write control fields
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ctl_loopback <= PBR_RST_LOOPBACK;
      ctl_speed    <= PBR_RST_SPEED;
      ctl_isolate  <= PBR_RST_ISOLATE;
      ctl_duplex   <= PBR_RST_DUPLEX;
      ctl_col_test <= PBR_RST_COL_TEST;
    end else if (full_reset) begin
      ctl_loopback <= PBR_RST_LOOPBACK; // [RULE13]
      ctl_speed    <= PBR_RST_SPEED;
      ctl_isolate  <= PBR_RST_ISOLATE;
      ctl_duplex   <= PBR_RST_DUPLEX;
      ctl_col_test <= PBR_RST_COL_TEST;
    end else if (wr_ctl && !i_reg_wdata[PBR_CTL_RESET]) begin
      ctl_loopback <= i_reg_wdata[PBR_CTL_LOOPBACK]; // [RULE3]
      ctl_speed    <= i_reg_wdata[PBR_CTL_SPEED];    // [RULE5]
      ctl_isolate  <= i_reg_wdata[PBR_CTL_ISOLATE];  // [RULE9]
      ctl_duplex   <= i_reg_wdata[PBR_CTL_DUPLEX];   // [RULE6]
      ctl_col_test <= i_reg_wdata[PBR_CTL_COL_TEST]; // [RULE11]
    end
  end

  // Vendor function control word at 1Ch (holds loopback enable)
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      func_ctrl <= PBR_RST_FUNC_CTRL;
    end else if (full_reset) begin
      func_ctrl <= PBR_RST_FUNC_CTRL;
    end else if (wr_fc) begin
      func_ctrl <= i_reg_wdata; // [RULE4]
    end
  end

  // ************************************************************
  // Self-clearing actions
  // ************************************************************
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      swrst_cnt    <= 3'h0;
      o_soft_reset <= 1'b0;
    end else if (full_reset) begin
      swrst_cnt    <= PBR_SWRST_CNT; // [RULE2]
      o_soft_reset <= 1'b1;
    end else if (swrst_cnt != 3'h0) begin
      swrst_cnt    <= swrst_cnt - 3'h1;
      o_soft_reset <= (swrst_cnt != 3'h1);
    end else begin
      o_soft_reset <= 1'b0;
    end
  end

  // Restart pulse; the bit itself never stores
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_neg_restart <= 1'b0;
    end else begin
      o_neg_restart <= wr_ctl && i_reg_wdata[PBR_CTL_NEG_RST]
                       && !i_reg_wdata[PBR_CTL_RESET]; // [RULE10]
    end
  end

  // ************************************************************
  // Effective mode and registered outputs
  // ************************************************************
  pbr_mode_resolve u_mode (
    .i_neg_enable   (ctl_neg_en),
    .i_neg_speed    (i_neg_speed),
    .i_neg_duplex   (i_neg_duplex),
    .i_ctl_speed    (ctl_speed),
    .i_ctl_duplex   (ctl_duplex),
    .i_ctl_loopback (ctl_loopback),
    .i_fc_loopback  (func_ctrl[PBR_FC_LOOPBACK]),
    .o_speed_100    (next_speed),
    .o_full_duplex  (next_duplex),
    .o_loopback     (next_loop)
  );

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_speed_100   <= PBR_RST_SPEED;
      o_full_duplex <= PBR_RST_DUPLEX;
      o_loopback    <= PBR_RST_LOOPBACK;
      o_power_down  <= PBR_RST_PWR_DOWN;
      o_isolate     <= PBR_RST_ISOLATE;
      o_col_test    <= PBR_RST_COL_TEST;
    end else begin
      o_speed_100   <= next_speed;   // [RULE5] [RULE6]
      o_full_duplex <= next_duplex;  // [RULE6]
      o_loopback    <= next_loop;    // [RULE3] [RULE4]
      o_power_down  <= ctl_pwr_down; // [RULE7]
      o_isolate     <= ctl_isolate;  // [RULE9]
      o_col_test    <= ctl_col_test; // [RULE11]
    end
  end

  // ************************************************************
  // Read path
  // ************************************************************
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_reg_rdata  <= 16'h0000;
      o_reg_rvalid <= 1'b0;
    end else begin
      o_reg_rvalid <= i_reg_rd;
      if (i_reg_rd) begin
        unique case (i_reg_addr)
          PBR_IDX_CONTROL:   o_reg_rdata <= control_image(ctl_loopback, ctl_speed,
                               ctl_neg_en, ctl_pwr_down, ctl_isolate, ctl_duplex,
                               ctl_col_test); // [RULE2] [RULE11]
          PBR_IDX_STATUS:    o_reg_rdata <= PBR_STATUS_VALUE; // [RULE12] [RULE13]
          PBR_IDX_FUNC_CTRL: o_reg_rdata <= func_ctrl;
          default:           o_reg_rdata <= 16'h0000; // [RULE1]
        endcase
      end
    end
  end
endmodule : pbr_regs
`default_nettype wire

// File: verification/pbr_regs_properties.sv
// Checker: port-level properties of the basic control and status bank
`default_nettype none
module pbr_regs_chk
  import pbr_pkg::*;
(
  input wire logic        i_core_clk,    // Clock
  input wire logic        i_rst_n,       // Reset, active low
  input wire logic [4:0]  i_reg_addr,    // Index
  input wire logic        i_reg_wr,      // Write strobe
  input wire logic        i_reg_rd,      // Read strobe
  input wire logic [15:0] i_reg_wdata,   // Write data
  input wire logic        i_neg_speed,   // Negotiated speed
  input wire logic        i_neg_duplex,  // Negotiated duplex
  input wire logic [15:0] o_reg_rdata,   // Read data
  input wire logic        o_reg_rvalid,  // Read valid
  input wire logic        o_soft_reset,  // Soft reset pulse
  input wire logic        o_neg_restart, // Restart pulse
  input wire logic        o_power_down,  // Power-down
  input wire logic        o_isolate,     // Isolate
  input wire logic        o_loopback,    // Loopback
  input wire logic        o_speed_100,   // Speed
  input wire logic        o_full_duplex, // Duplex
  input wire logic        o_col_test     // Collision test
);
  timeunit 1ns;
  timeprecision 1ps;
  // ************************************************************
  // Properties
  // ************************************************************
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);
  // Plain control write, no reset bit
  wire w0 = i_reg_wr && i_reg_addr == PBR_IDX_CONTROL && !i_reg_wdata[15];
  rvalid_pulse_a: assert property (
    i_reg_rd |=> o_reg_rvalid) else $error("no read valid");
  unmapped_zero_a: assert property (
    i_reg_rd && i_reg_addr > 5'h01 && i_reg_addr != 5'h1c |=> o_reg_rdata == 16'h0000)
    else $error("unmapped read not zero");
  status_image_a: assert property (
    i_reg_rd && i_reg_addr == PBR_IDX_STATUS |=> o_reg_rdata == 16'h7000) else $error("bad status");
  ctl_zero_bits_a: assert property (
    i_reg_rd && i_reg_addr == PBR_IDX_CONTROL |=> o_reg_rdata[15] == 1'b0
    && o_reg_rdata[9] == 1'b0 && o_reg_rdata[6:0] == 7'h00) else $error("control zero bits set");
  restart_pulse_a: assert property (
    w0 && i_reg_wdata[9] |=> o_neg_restart ##1 !o_neg_restart) else $error("bad restart pulse");
  swrst_len_a: assert property (
    $rose(o_soft_reset) |-> o_soft_reset [*4] ##1 !o_soft_reset) else $error("bad reset length");
  swrst_fields_a: assert property (
    $rose(o_soft_reset) |=> !o_power_down && !o_isolate && !o_col_test && !o_loopback)
    else $error("fields not reset");
  mode_follow_a: assert property (
    w0 |-> ##2 o_power_down == $past(i_reg_wdata[11], 2) && o_isolate == $past(i_reg_wdata[10], 2)
    && o_col_test == $past(i_reg_wdata[7], 2)) else $error("mode output wrong");
  forced_mode_a: assert property (
    w0 && !i_reg_wdata[12] |-> ##2 o_speed_100 == $past(i_reg_wdata[13], 2)
    && o_full_duplex == $past(i_reg_wdata[8], 2)) else $error("forced mode wrong");
  // Output flop samples the negotiated levels one cycle before it is seen
  neg_override_a: assert property (
    w0 && i_reg_wdata[12] |-> ##2 o_speed_100 == $past(i_neg_speed, 1)
    && o_full_duplex == $past(i_neg_duplex, 1)) else $error("negotiated mode wrong");
  cover property ($rose(o_soft_reset));
  cover property ($rose(o_neg_restart));
  cover property ($rose(o_power_down));
endmodule : pbr_regs_chk
`default_nettype wire

// File: verification/pbr_mgmt_model.sv
// Model: management controller issuing register reads and writes
`default_nettype none
module pbr_mgmt_model (
  input  wire logic        i_core_clk, // Clock
  input  wire logic [15:0] i_rdata,    // Read data
  input  wire logic        i_rvalid,   // Read valid
  output var logic  [4:0]  o_addr,     // Index
  output var logic         o_wr,       // Write strobe
  output var logic         o_rd,       // Read strobe
  output var logic  [15:0] o_wdata     // Write data
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle bus at time zero
  initial begin
    o_addr = 5'h00;
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_wdata = 16'h0000;
  end
  // One-cycle write; data inverted after so stale values never match
  task automatic write_reg(input logic [4:0] a, input logic [15:0] d);
    @(negedge i_core_clk);
    o_addr = a;
    o_wdata = d;
    o_wr = 1'b1;
    @(negedge i_core_clk);
    o_wr = 1'b0;
    o_wdata = ~d;
  endtask : write_reg
  // One-cycle read; answer taken one cycle later
  task automatic read_reg(input logic [4:0] a, output logic [15:0] d, output logic ok);
    @(negedge i_core_clk);
    o_addr = a;
    o_rd = 1'b1;
    @(negedge i_core_clk);
    o_rd = 1'b0;
    ok = (i_rvalid === 1'b1);
    d = i_rdata;
  endtask : read_reg
endmodule : pbr_mgmt_model
`default_nettype wire

// File: verification/tb.sv
// Testbench: register access sequences for the control and status bank
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rst_n, strap, nsp, ndx, wr, rd, rvalid, ok;
  logic        swrst, restart, pd, iso, lb, sp, fd, ct;
  logic [4:0]  addr;
  logic [15:0] wdata, rdata, n;
  logic [15:0] mode_tab [4] = '{16'h0000, 16'h2100, 16'h2000, 16'h0100};
  int          err_count, n_compared;
  pbr_regs u_pbr_regs (.i_core_clk(clk), .i_rst_n(rst_n), .i_negotiation_enable_strap(strap),
    .i_reg_addr(addr), .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_wdata(wdata), .i_neg_speed(nsp),
    .i_neg_duplex(ndx), .o_reg_rdata(rdata), .o_reg_rvalid(rvalid), .o_soft_reset(swrst),
    .o_neg_restart(restart), .o_power_down(pd), .o_isolate(iso), .o_loopback(lb),
    .o_speed_100(sp), .o_full_duplex(fd), .o_col_test(ct));
  pbr_mgmt_model u_pbr_mgmt_model (.i_core_clk(clk), .i_rdata(rdata), .i_rvalid(rvalid),
    .o_addr(addr), .o_wr(wr), .o_rd(rd), .o_wdata(wdata));
  // ************************************************************
  // Checking helpers
  // ************************************************************
  task automatic chk_word(input string s, input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("wrong value %s: expected %h, seen %h", s, e, g);
    end
  endtask : chk_word
  task automatic chk_bit(input string s, input logic e, input logic g);
    chk_word(s, {15'h0000, e}, {15'h0000, g});
  endtask : chk_bit
  task automatic rd_chk(input logic [4:0] a, input logic [15:0] e, input string s);
    u_pbr_mgmt_model.read_reg(a, n, ok);
    chk_bit("read valid", 1'b1, ok);
    chk_word(s, e, n);
  endtask : rd_chk
  task automatic wr_reg(input logic [4:0] a, input logic [15:0] d);
    u_pbr_mgmt_model.write_reg(a, d);
  endtask : wr_reg
  task automatic stop_test();
    $display("comparisons %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : stop_test
  // Clock and watchdog
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    repeat (5000) @(posedge clk);
    err_count++;
    stop_test();
  end
  // Main sequence
  initial begin
    strap = 1'b1;
    nsp = 1'b0;
    ndx = 1'b0;
    rst_n = 1'b0;
    repeat (20) @(posedge clk);
    @(negedge clk) rst_n = 1'b1;
    repeat (2) @(negedge clk);
    rd_chk(5'h00, 16'h3100, "control reset");
    chk_bit("negotiated speed", 1'b0, sp);
    rd_chk(5'h01, 16'h7000, "status");
    wr_reg(5'h01, 16'h8fff);
    chk_bit("status write reset", 1'b0, swrst);
    rd_chk(5'h01, 16'h7000, "status kept");
    for (int i = 2; i < 32; i++) begin
      if (i != 28) rd_chk(5'(i), 16'h0000, "unmapped");
    end
    foreach (mode_tab[k]) begin
      wr_reg(5'h00, mode_tab[k]);
      @(negedge clk);
      chk_bit("forced speed", mode_tab[k][13], sp);
      chk_bit("forced duplex", mode_tab[k][8], fd);
    end
    nsp = 1'b1;
    ndx = 1'b1;
    wr_reg(5'h00, 16'h1200);
    chk_bit("restart high", 1'b1, restart);
    @(negedge clk);
    chk_bit("restart low", 1'b0, restart);
    chk_bit("override speed", 1'b1, sp);
    chk_bit("override duplex", 1'b1, fd);
    rd_chk(5'h00, 16'h1000, "restart cleared");
    wr_reg(5'h00, 16'h54ff);
    @(negedge clk);
    chk_bit("loopback half", 1'b0, lb);
    chk_bit("isolate", 1'b1, iso);
    chk_bit("collision test", 1'b1, ct);
    rd_chk(5'h00, 16'h5480, "control image");
    wr_reg(5'h1c, 16'h0001);
    @(negedge clk);
    chk_bit("loopback on", 1'b1, lb);
    rd_chk(5'h1c, 16'h0001, "function control");
    wr_reg(5'h00, 16'h5c80);
    @(negedge clk);
    chk_bit("power down", 1'b1, pd);
    strap = 1'b0;
    wr_reg(5'h00, 16'h8000);
    chk_bit("first reset write", 1'b0, swrst);
    @(negedge clk);
    chk_bit("power down cleared", 1'b0, pd);
    wr_reg(5'h00, 16'h8000);
    n = 16'h0000;
    while (swrst === 1'b1 && n < 16'h000a) begin
      n++;
      @(negedge clk);
    end
    chk_word("reset pulse length", 16'h0004, n);
    rd_chk(5'h00, 16'h2100, "control after reset");
    rd_chk(5'h1c, 16'h0000, "function after reset");
    chk_bit("loopback after reset", 1'b0, lb);
    chk_bit("speed after reset", 1'b1, sp);
    // Mid-run asynchronous reset: outputs return to reset values, strap re-read
    wr_reg(5'h00, 16'h0080);
    rd_chk(5'h00, 16'h0080, "control before reset");
    strap = 1'b1;
    rst_n = 1'b0;
    @(negedge clk);
    chk_bit("collision test in reset", 1'b0, ct);
    chk_bit("speed in reset", 1'b1, sp);
    chk_word("read data in reset", 16'h0000, rdata);
    rst_n = 1'b1;
    repeat (2) @(negedge clk);
    rd_chk(5'h00, 16'h3100, "control after async reset");
    stop_test();
  end
endmodule : tb
bind pbr_regs pbr_regs_chk u_pbr_regs_chk (.i_core_clk, .i_rst_n, .i_reg_addr, .i_reg_wr,
  .i_reg_rd, .i_reg_wdata, .i_neg_speed, .i_neg_duplex, .o_reg_rdata, .o_reg_rvalid,
  .o_soft_reset, .o_neg_restart, .o_power_down, .o_isolate, .o_loopback, .o_speed_100,
  .o_full_duplex, .o_col_test);
`default_nettype wire
